// ===== dmarb_pkg.sv
package dmarb_pkg;

  localparam int          MASTER_COUNT  = 3;
  localparam int          LEVEL_COUNT   = 5;
  localparam int          PRIO_WIDTH    = 16;

  // requester indices
  localparam int          IDX_CORE      = 0;
  localparam int          IDX_DMA       = 1;
  localparam int          IDX_DEBUG     = 2;

  // master_priority_control values
  localparam logic [15:0] PRIO_DEFAULT  = 16'h0000;
  localparam logic [15:0] PRIO_DMA_HIGH = 16'h0020;
  localparam logic [15:0] PRIO_RESET    = 16'h0000;

  // level of each master in each scheme
  localparam logic [2:0]  LVL_CORE_DEF  = 3'h0;
  localparam logic [2:0]  LVL_DMA_DEF   = 3'h3;
  localparam logic [2:0]  LVL_DMA_HIGH  = 3'h0;
  localparam logic [2:0]  LVL_CORE_LOW  = 3'h1;
  localparam logic [2:0]  LVL_DEBUG     = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY
  } dmarb_state_type;

endpackage : dmarb_pkg

// ===== dmarb_level_map.sv
`timescale 1ns/1ps
// maps the priority control word to a level per master
module dmarb_level_map (
  input  wire logic [15:0] masterPriorityControl,
  output logic      [2:0]  levelCore,
  output logic      [2:0]  levelDma,
  output logic      [2:0]  levelDebug
);

  always_comb begin
    // reserved control values fall back to the default order
    if (masterPriorityControl == dmarb_pkg::PRIO_DMA_HIGH) begin
      levelDma  = dmarb_pkg::LVL_DMA_HIGH;
      levelCore = dmarb_pkg::LVL_CORE_LOW;
    end else begin
      levelCore = dmarb_pkg::LVL_CORE_DEF;
      levelDma  = dmarb_pkg::LVL_DMA_DEF;
    end
    levelDebug = dmarb_pkg::LVL_DEBUG;
  end

endmodule : dmarb_level_map

// ===== dmarb_arbiter.sv
`timescale 1ns/1ps
// Behaviour
// - Data memory and extended_data_space accesses come from core, DMA and debug_bus_master requesters.
// - Among simultaneous requests only the highest priority one is granted; the rest wait their turn.
// - By default the core sits at level 0 and the debug master at level 4.
// - By default DMA sits at level 3, and levels 1 and 2 are never assigned.
// - Control value 0x0000 orders core, DMA, debug; value 0x0020 orders DMA, core, debug.
// - Masters raised above the core keep their original order among themselves.
// - Masters left below the core keep their original order among themselves.
// - The control value may change at any time and new arbitrations follow it.
module dmarb_arbiter #(
  parameter int MASTERS = dmarb_pkg::MASTER_COUNT
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [15:0]  masterPriorityControl,
  input  wire logic         reqCore,
  input  wire logic         reqDma,
  input  wire logic         reqDebug,
  input  wire logic         doneCore,
  input  wire logic         doneDma,
  input  wire logic         doneDebug,
  output logic              grantCore,
  output logic              grantDma,
  output logic              grantDebug,
  output logic              busBusy,
  output logic [15:0]       activePriority
);

  initial begin
    if (MASTERS != dmarb_pkg::MASTER_COUNT) begin
      $error("dmarb_arbiter serves exactly three masters");
    end
  end

  logic [2:0]                  levelCore;
  logic [2:0]                  levelDma;
  logic [2:0]                  levelDebug;
  logic [15:0]                 prio_r;
  logic [15:0]                 prio_nxt;
  dmarb_pkg::dmarb_state_type  state_r;
  dmarb_pkg::dmarb_state_type  state_nxt;
  logic [2:0]                  grant_r;
  logic [2:0]                  grant_nxt;
  logic [2:0]                  req;
  logic [2:0]                  done;
  logic [2:0]                  pick;

  assign req  = {reqDebug, reqDma, reqCore};
  assign done = {doneDebug, doneDma, doneCore};

  // control taken only between accesses so a live grant never flips
  always_comb begin
    prio_nxt = prio_r;
    if (state_r == dmarb_pkg::ST_IDLE) begin
      prio_nxt = masterPriorityControl;
    end
  end

  dmarb_level_map u_map (
    .masterPriorityControl (prio_nxt),
    .levelCore             (levelCore),
    .levelDma              (levelDma),
    .levelDebug            (levelDebug)
  );

  // lowest level wins; debug always last, ties impossible by construction
  always_comb begin
    pick = 3'h0;
    if (req[dmarb_pkg::IDX_CORE] && (!req[dmarb_pkg::IDX_DMA] || levelCore < levelDma)) begin
      pick[dmarb_pkg::IDX_CORE] = 1'b1;
    end else if (req[dmarb_pkg::IDX_DMA]) begin
      pick[dmarb_pkg::IDX_DMA] = 1'b1;
    end else if (req[dmarb_pkg::IDX_DEBUG] && levelDebug == dmarb_pkg::LVL_DEBUG) begin
      pick[dmarb_pkg::IDX_DEBUG] = 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    grant_nxt = grant_r;
    case (state_r)
      dmarb_pkg::ST_IDLE: begin
        if (pick != 3'h0) begin
          grant_nxt = pick;
          state_nxt = dmarb_pkg::ST_BUSY;
        end
      end
      dmarb_pkg::ST_BUSY: begin
        // losers stay pending until the holder finishes
        if ((grant_r & done) != 3'h0) begin
          grant_nxt = 3'h0;
          state_nxt = dmarb_pkg::ST_IDLE;
        end
      end
      default: begin
        grant_nxt = 3'h0;
        state_nxt = dmarb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= dmarb_pkg::ST_IDLE;
      grant_r <= 3'h0;
      prio_r  <= dmarb_pkg::PRIO_RESET;
    end else begin
      state_r <= state_nxt;
      grant_r <= grant_nxt;
      prio_r  <= prio_nxt;
    end
  end

  assign grantCore      = grant_r[dmarb_pkg::IDX_CORE];
  assign grantDma       = grant_r[dmarb_pkg::IDX_DMA];
  assign grantDebug     = grant_r[dmarb_pkg::IDX_DEBUG];
  assign busBusy        = (state_r == dmarb_pkg::ST_BUSY);
  assign activePriority = prio_r;

endmodule : dmarb_arbiter

// ===== dmarb_sva.sv
`timescale 1ns/1ps
module dmarb_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        reqCore,
  input wire logic        reqDma,
  input wire logic        reqDebug,
  input wire logic        doneCore,
  input wire logic        doneDma,
  input wire logic        doneDebug,
  input wire logic        grantCore,
  input wire logic        grantDma,
  input wire logic        grantDebug,
  input wire logic        busBusy,
  input wire logic [15:0] masterPriorityControl,
  input wire logic [15:0] activePriority
);
  wire [2:0] g = {grantDebug, grantDma, grantCore};
  wire e = |(g & {doneDebug, doneDma, doneCore});
  wire any = reqCore || reqDma || reqDebug;
  wire t = !busBusy && any;
  wire h = masterPriorityControl == 16'h0020;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_one; $onehot0(g) && busBusy == (|g); endproperty
  a_one: assert property (p_one) else $error("one");
  property p_cpu; t && reqCore && !h |=> grantCore; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu");
  property p_dma; t && reqDma && (h || !reqCore) |=> grantDma; endproperty
  a_dma: assert property (p_dma) else $error("dma");
  property p_dbg; t && (reqCore || reqDma) |=> !grantDebug; endproperty
  a_dbg: assert property (p_dbg) else $error("dbg");
  property p_low; t && !reqCore && !reqDma |=> grantDebug; endproperty
  a_low: assert property (p_low) else $error("low");
  property p_new; t |=> busBusy && activePriority == $past(masterPriorityControl); endproperty
  a_new: assert property (p_new) else $error("new");
  property p_hold; busBusy && !e |=> $stable(g); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_end; e |=> !busBusy ##1 busBusy == $past(any); endproperty
  a_end: assert property (p_end) else $error("end");
  c_dma: cover property (grantDma && h);
  c_dbg: cover property (grantDebug);
  c_end: cover property (e ##2 busBusy);
endmodule : dmarb_sva
bind dmarb_arbiter dmarb_sva u_sva (.clock, .rst, .reqCore, .reqDma, .reqDebug, .doneCore, .doneDma, .doneDebug,
  .grantCore, .grantDma, .grantDebug, .busBusy, .masterPriorityControl, .activePriority);

// ===== dmarb_masters.sv
`timescale 1ns/1ps
module dmarb_masters (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [2:0] start,
  input  wire logic [2:0] grant,
  input  wire logic [1:0] delay,
  output logic      [2:0] req_r,
  output logic      [2:0] done_r
);
  logic [2:0] req_nxt, done_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  always_comb begin
    req_nxt = (req_r | start) & ~done_r;
    done_nxt = grant & ~done_r & {3{cnt_r == 2'h0}};
    cnt_nxt = (|grant) ? cnt_r - {1'b0, cnt_r != 2'h0} : delay;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) {req_r, done_r, cnt_r} <= 8'h00;
    else {req_r, done_r, cnt_r} <= {req_nxt, done_nxt, cnt_nxt};
  end
endmodule : dmarb_masters

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0, rst = 1'b1, busBusy;
  logic [15:0] ctrl = 16'h0000, act;
  logic [2:0] start = 3'h0, req, done, g, pg = 3'h0;
  logic [1:0] delay = 2'h0;
  logic [18:0] q[$];
  int fails = 0, check_count = 0, cycles = 0, seed = 60840, m, j;
  always #2 clock = ~clock;
  dmarb_arbiter DUT (.clock, .rst, .masterPriorityControl(ctrl), .reqCore(req[0]), .reqDma(req[1]),
    .reqDebug(req[2]), .doneCore(done[0]), .doneDma(done[1]), .doneDebug(done[2]), .grantCore(g[0]),
    .grantDma(g[1]), .grantDebug(g[2]), .busBusy, .activePriority(act));
  dmarb_masters u_m (.clock, .rst, .start, .grant(g), .delay, .req_r(req), .done_r(done));
  task chk(input logic [18:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR grant exp %h seen %h", exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // look off the launching edge so the grant has settled
  always @(negedge clock) begin
    if (g !== 3'h0 && pg === 3'h0) chk({act, g}, (q.size() != 0) ? q.pop_front() : 19'h0);
    pg <= g;
  end
  always @(negedge clock) if (++cycles == 4000) begin
    fails++;
    test_done;
  end
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk({act, g}, 19'h0);
    repeat (60) begin
      m = $random(seed);
      ctrl = m[3] ? 16'h0020 : 16'h0000;
      delay = m[5:4];
      start = (m[2:0] == 3'h0) ? 3'h7 : m[2:0];
      for (int k = 0; k < 3; k++) begin
        j = (m[3] && k < 2) ? 1 - k : k;
        if (start[j]) q.push_back({ctrl, 3'h1 << j});
      end
      @(negedge clock);
      start = 3'h0;
      while (req !== 3'h0 || busBusy !== 1'b0) @(negedge clock);
    end
    @(negedge clock);
    chk(19'(q.size()), 19'h0);
    test_done;
  end
endmodule : tb_top
